// ---- rtl/tmr_defs.vh ----
// Purpose: register map, field positions, reset values for tmr16_ctrl
// Assumes: 32-bit avalon data, byte addresses, one word per register
// Notes:   definitions only
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TMR_OFS_CTRL_ONE   8'h00
`define TMR_OFS_CTRL_TWO   8'h04
`define TMR_OFS_STATUS     8'h08
`define TMR_OFS_COUNT      8'h0C
`define TMR_OFS_CMP_ONE    8'h10
`define TMR_OFS_CMP_TWO    8'h14
`define TMR_OFS_CAP_ONE    8'h18
`define TMR_OFS_CAP_TWO    8'h1C

// ----------------------------------------
// control one fields
// ----------------------------------------
`define TMR_C1_CAP_IE      7
`define TMR_C1_CMP_IE      6
`define TMR_C1_OVF_IE      5
`define TMR_C1_FORCE_TWO   4
`define TMR_C1_FORCE_ONE   3
`define TMR_C1_LEVEL_TWO   2
`define TMR_C1_CAP1_EDGE   1
`define TMR_C1_LEVEL_ONE   0

// ----------------------------------------
// control two fields
// ----------------------------------------
`define TMR_C2_PIN1_EN     7
`define TMR_C2_PIN2_EN     6
`define TMR_C2_ONE_PULSE   5
`define TMR_C2_PWM         4
`define TMR_C2_CLK_HI      3
`define TMR_C2_CLK_LO      2
`define TMR_C2_CAP2_EDGE   1
`define TMR_C2_EXT_EDGE    0

// ----------------------------------------
// status fields (write one to clear)
// ----------------------------------------
`define TMR_ST_CAP_ONE     4
`define TMR_ST_CMP_ONE     3
`define TMR_ST_OVF         2
`define TMR_ST_CAP_TWO     1
`define TMR_ST_CMP_TWO     0

// ----------------------------------------
// reset values and clock selects
// ----------------------------------------
`define TMR_CTRL_RESET     8'h00
`define TMR_CNT_RESET      16'hFFFC
`define TMR_CAP_OPM        16'hFFFD
`define TMR_CMP_RESET      16'h8000
`define TMR_CLK_DIV4       2'h0
`define TMR_CLK_DIV2       2'h1
`define TMR_CLK_DIV8       2'h2
`define TMR_CLK_EXT        2'h3
`define TMR_TERM_DIV4      3'h3
`define TMR_TERM_DIV2      3'h1
`define TMR_TERM_DIV8      3'h7

`endif

// ---- rtl/tmr16_ctrl.v ----
// Purpose: 16-bit free-running timer with control, low power and events
// Assumes: avalon-mm slave, 10 MHz clock_in, async active-low reset
// Notes:   pins pass two flip-flops before use
//
// What this block does
// - in wait the timer keeps running; enabled interrupts wake from wait
// - halt freezes counter; resumes from held value, reset restarts it
// - capture edge during halt arms capture; stored when halt ends
// - capture flag one set by capture one, opm start, pwm reset or a capture armed in halt at halt end
// - all events share one request, needing enable and cleared cpu mask
// - flash timer a variant holds capture two and compare two flags zero
// - capture enable requests interrupt when either capture flag set
// - compare enable requests interrupt when either compare flag set
// - overflow enable requests interrupt when overflow flag set
// - force two drives pin two to level two outside pwm and opm, if pin two enabled
// - force one drives pin one to level one outside pwm and opm, if pin one enabled
// - compare two match drives level two; in pwm onto pin one, in opm the start edge does
// - capture one edge select: 0 falling, 1 rising
// - compare one match drives level one onto pin one when enabled
// - pin one enable only routes output; compare one stays active
// - pin two enable only routes output; software keeps it zero in flash
// - one pulse mode: capture one edge starts pulse, length by compare one
// - pwm mode: pulse length by compare one, period by compare two
// - clock select 00 div4, 01 div2, 10 div8, 11 external pin
// - external select without external pin stops the counter
// - external edge select: 0 falling, 1 rising edges count
// - capture two edge select: 0 falling, 1 rising
// - with pwm and one pulse both set only pwm operates
`timescale 1ns/10ps
`include "tmr_defs.vh"

module tmr16_ctrl #(
    parameter HAS_EXT_PIN   = 1,
    parameter FLASH_TIMER_A = 0
) (
    input  wire        clock_in,
    input  wire        reset_n_in,
    input  wire [7:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output wire [31:0] avs_readdata_out,
    output wire        avs_waitrequest_out,
    input  wire        cpu_wait_in,
    input  wire        cpu_halt_in,
    input  wire        cpu_irq_mask_in,
    input  wire        capture_pin_one_in,
    input  wire        capture_pin_two_in,
    input  wire        external_count_pin_in,
    output wire        timer_irq_out,
    output wire        wait_wake_out,
    output wire        compare_pin_one_out,
    output wire        compare_pin_one_sel_out,
    output wire        compare_pin_two_out,
    output wire        compare_pin_two_sel_out
);

// ----------------------------------------
// helpers
// ----------------------------------------
function edge_hit;
    input prev;
    input cur;
    input rising;
    begin
        edge_hit = rising ? (cur & ~prev) : (prev & ~cur);
    end
endfunction

function flag_next;
    input set;
    input old;
    input clr_bit;
    begin
        flag_next = set | (old & ~clr_bit);
    end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
reg  [7:0]  ctrl_one_r;
reg  [7:0]  ctrl_two_r;
reg  [15:0] cnt_r;
reg  [15:0] cmp_one_r;
reg  [15:0] cmp_two_r;
reg  [15:0] cap_one_r;
reg  [15:0] cap_two_r;
reg  [2:0]  psc_r;
reg         cap_one_flag_r;
reg         cap_two_flag_r;
reg         cmp_one_flag_r;
reg         cmp_two_flag_r;
reg         ovf_flag_r;
reg         pin_one_r;
reg         pin_two_r;
reg         arm_one_r;
reg         arm_two_r;
reg         halt_prev_r;
reg  [2:0]  cap1_sync_r;
reg  [2:0]  cap2_sync_r;
reg  [2:0]  ext_sync_r;
reg         wait_r;
reg  [31:0] rdata_r;
reg         irq_r;
reg         wake_r;

// ----------------------------------------
// bus decode
// ----------------------------------------
wire        req      = avs_read_in | avs_write_in;
wire        wr_take  = avs_write_in & ~wait_r;
wire        wr_ctrl1 = wr_take & (avs_address_in == `TMR_OFS_CTRL_ONE) & avs_byteenable_in[0];
wire        wr_ctrl2 = wr_take & (avs_address_in == `TMR_OFS_CTRL_TWO) & avs_byteenable_in[0];
wire        wr_stat  = wr_take & (avs_address_in == `TMR_OFS_STATUS) & avs_byteenable_in[0];
wire        wr_count = wr_take & (avs_address_in == `TMR_OFS_COUNT);
wire        wr_cmp1  = wr_take & (avs_address_in == `TMR_OFS_CMP_ONE);
wire        wr_cmp2  = wr_take & (avs_address_in == `TMR_OFS_CMP_TWO);
wire [4:0]  clr      = wr_stat ? avs_writedata_in[4:0] : 5'h00;

// ----------------------------------------
// mode decode
// ----------------------------------------
wire        pwm_mode = ctrl_two_r[`TMR_C2_PWM];
wire        opm_mode = ctrl_two_r[`TMR_C2_ONE_PULSE] & ~pwm_mode;
wire [1:0]  clk_sel  = ctrl_two_r[`TMR_C2_CLK_HI:`TMR_C2_CLK_LO];
// halt is a same-clock level from the cpu, so no synchroniser
wire        halted   = cpu_halt_in;
wire        halt_end = halt_prev_r & ~cpu_halt_in;

// ----------------------------------------
// timer tick
// ----------------------------------------
reg  [2:0]  term;
always @* begin
    case (clk_sel)
        `TMR_CLK_DIV4: term = `TMR_TERM_DIV4;
        `TMR_CLK_DIV2: term = `TMR_TERM_DIV2;
        default:       term = `TMR_TERM_DIV8;
    endcase
end

wire ext_edge = edge_hit(ext_sync_r[2], ext_sync_r[1],
                         ctrl_two_r[`TMR_C2_EXT_EDGE]);
wire ext_tick = (HAS_EXT_PIN != 0) & ext_edge;
wire int_tick = (clk_sel != `TMR_CLK_EXT) & (psc_r == term);
// halt stops prescaler too, wait does not
wire tick     = ~halted & ((clk_sel == `TMR_CLK_EXT) ? ext_tick : int_tick);

// ----------------------------------------
// events
// ----------------------------------------
wire cap1_edge = edge_hit(cap1_sync_r[2], cap1_sync_r[1],
                          ctrl_one_r[`TMR_C1_CAP1_EDGE]);
wire cap2_edge = edge_hit(cap2_sync_r[2], cap2_sync_r[1],
                          ctrl_two_r[`TMR_C2_CAP2_EDGE]);
wire match1    = tick & (cnt_r == cmp_one_r);
wire match2    = tick & (cnt_r == cmp_two_r);
wire opm_start = opm_mode & cap1_edge & ~halted;
wire pwm_wrap  = pwm_mode & match2;
// pwm and one pulse own capture pin one
wire cap1_now  = ~halted & ~pwm_mode & ~opm_mode & cap1_edge;
wire cap2_now  = ~halted & cap2_edge;
wire cap1_wake = halt_end & arm_one_r;
wire cap2_wake = halt_end & arm_two_r;
wire ovf_ev    = tick & (cnt_r == 16'hFFFF) & ~pwm_wrap;
wire set_cap1  = cap1_now | cap1_wake | opm_start | pwm_wrap;
wire set_cap2  = (FLASH_TIMER_A == 0) & (cap2_now | cap2_wake);
wire set_cmp1  = match1 & ~pwm_mode & ~opm_mode;
wire set_cmp2  = (FLASH_TIMER_A == 0) & match2 & ~pwm_mode;

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
// the second and third stages feed edge detection
always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        cap1_sync_r <= 3'h0;
        cap2_sync_r <= 3'h0;
        ext_sync_r  <= 3'h0;
        halt_prev_r <= 1'b0;
    end else begin
        cap1_sync_r <= {cap1_sync_r[1:0], capture_pin_one_in};
        cap2_sync_r <= {cap2_sync_r[1:0], capture_pin_two_in};
        ext_sync_r  <= {ext_sync_r[1:0], external_count_pin_in};
        halt_prev_r <= cpu_halt_in;
    end
end

// ----------------------------------------
// bus slave
// ----------------------------------------
// one idle cycle then one ack cycle; readdata stands during ack
// read data is a snapshot at the request edge, so a count read may lag a tick
always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        wait_r  <= 1'b1;
        rdata_r <= 32'h0000_0000;
    end else begin
        if (req & wait_r) begin
            wait_r <= 1'b0;
            case (avs_address_in)
                `TMR_OFS_CTRL_ONE: rdata_r <= {24'h000000, ctrl_one_r};
                `TMR_OFS_CTRL_TWO: rdata_r <= {24'h000000, ctrl_two_r};
                `TMR_OFS_STATUS:   rdata_r <= {27'h0000000, cap_one_flag_r,
                                               cmp_one_flag_r, ovf_flag_r,
                                               cap_two_flag_r, cmp_two_flag_r};
                `TMR_OFS_COUNT:    rdata_r <= {16'h0000, cnt_r};
                `TMR_OFS_CMP_ONE:  rdata_r <= {16'h0000, cmp_one_r};
                `TMR_OFS_CMP_TWO:  rdata_r <= {16'h0000, cmp_two_r};
                `TMR_OFS_CAP_ONE:  rdata_r <= {16'h0000, cap_one_r};
                `TMR_OFS_CAP_TWO:  rdata_r <= {16'h0000, cap_two_r};
                default:           rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            wait_r <= 1'b1;
        end
    end
end

// ----------------------------------------
// control and data registers
// ----------------------------------------
always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        ctrl_one_r <= `TMR_CTRL_RESET;
        ctrl_two_r <= `TMR_CTRL_RESET;
        cmp_one_r  <= `TMR_CMP_RESET;
        cmp_two_r  <= `TMR_CMP_RESET;
    end else begin
        if (wr_ctrl1) begin
            ctrl_one_r <= avs_writedata_in[7:0];
        end
        if (wr_ctrl2) begin
            ctrl_two_r <= avs_writedata_in[7:0];
        end
        if (wr_cmp1) begin
            cmp_one_r <= avs_writedata_in[15:0];
        end
        if (wr_cmp2) begin
            cmp_two_r <= avs_writedata_in[15:0];
        end
    end
end

// ----------------------------------------
// counter and prescaler
// ----------------------------------------
// a count write restarts counting; prescaler phase is kept to save logic
always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        cnt_r <= `TMR_CNT_RESET;
        psc_r <= 3'h0;
    end else begin
        if (~halted) begin
            psc_r <= int_tick ? 3'h0 : psc_r + 3'h1;
        end
        if (wr_count | opm_start | pwm_wrap) begin
            cnt_r <= `TMR_CNT_RESET;
        end else if (tick) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
end

// ----------------------------------------
// capture registers and halt arming
// ----------------------------------------
always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        cap_one_r <= 16'h0000;
        cap_two_r <= 16'h0000;
        arm_one_r <= 1'b0;
        arm_two_r <= 1'b0;
    end else begin
        if (opm_start) begin
            cap_one_r <= `TMR_CAP_OPM;
        end else if (cap1_now | cap1_wake) begin
            cap_one_r <= cnt_r;
        end
        if (cap2_now | cap2_wake) begin
            cap_two_r <= cnt_r;
        end
        if (halt_end) begin
            arm_one_r <= 1'b0;
            arm_two_r <= 1'b0;
        end else if (halted) begin
            arm_one_r <= arm_one_r | (cap1_edge & ~pwm_mode);
            arm_two_r <= arm_two_r | cap2_edge;
        end
    end
end

// ----------------------------------------
// status flags, set beats clear
// ----------------------------------------
always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        cap_one_flag_r <= 1'b0;
        cap_two_flag_r <= 1'b0;
        cmp_one_flag_r <= 1'b0;
        cmp_two_flag_r <= 1'b0;
        ovf_flag_r     <= 1'b0;
    end else begin
        cap_one_flag_r <= flag_next(set_cap1, cap_one_flag_r, clr[`TMR_ST_CAP_ONE]);
        cap_two_flag_r <= flag_next(set_cap2, cap_two_flag_r, clr[`TMR_ST_CAP_TWO]);
        cmp_one_flag_r <= flag_next(set_cmp1, cmp_one_flag_r, clr[`TMR_ST_CMP_ONE]);
        cmp_two_flag_r <= flag_next(set_cmp2, cmp_two_flag_r, clr[`TMR_ST_CMP_TWO]);
        ovf_flag_r     <= flag_next(ovf_ev, ovf_flag_r, clr[`TMR_ST_OVF]);
    end
end

// ----------------------------------------
// compare outputs
// ----------------------------------------
// pin enables only steer the pad mux; levels update regardless
always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        pin_one_r <= 1'b0;
        pin_two_r <= 1'b0;
    end else begin
        if (pwm_mode | opm_mode) begin
            if (opm_start | pwm_wrap) begin
                pin_one_r <= ctrl_one_r[`TMR_C1_LEVEL_TWO];
            end else if (match1) begin
                pin_one_r <= ctrl_one_r[`TMR_C1_LEVEL_ONE];
            end
        end else begin
            // forcing is ignored in opm and pwm
            if (ctrl_one_r[`TMR_C1_FORCE_ONE] | match1) begin
                pin_one_r <= ctrl_one_r[`TMR_C1_LEVEL_ONE];
            end
            if (ctrl_one_r[`TMR_C1_FORCE_TWO] | match2) begin
                pin_two_r <= ctrl_one_r[`TMR_C1_LEVEL_TWO];
            end
        end
    end
end

// ----------------------------------------
// interrupt request and wait wake
// ----------------------------------------
// mask gates the vector request only; the wait wake ignores it
wire ev_req = (ctrl_one_r[`TMR_C1_CAP_IE] & (cap_one_flag_r | cap_two_flag_r))
            | (ctrl_one_r[`TMR_C1_CMP_IE] & (cmp_one_flag_r | cmp_two_flag_r))
            | (ctrl_one_r[`TMR_C1_OVF_IE] & ovf_flag_r);

always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        irq_r  <= 1'b0;
        wake_r <= 1'b0;
    end else begin
        irq_r  <= ev_req & ~cpu_irq_mask_in;
        // timer events never wake from halt
        wake_r <= ev_req & cpu_wait_in & ~cpu_halt_in;
    end
end

// ----------------------------------------
// outputs
// ----------------------------------------
assign avs_readdata_out        = rdata_r;
assign avs_waitrequest_out     = wait_r;
assign timer_irq_out           = irq_r;
assign wait_wake_out           = wake_r;
assign compare_pin_one_out     = pin_one_r;
assign compare_pin_one_sel_out = ctrl_two_r[`TMR_C2_PIN1_EN];
assign compare_pin_two_out     = pin_two_r;
assign compare_pin_two_sel_out = ctrl_two_r[`TMR_C2_PIN2_EN];

endmodule

// ---- tb/tmr16_ctrl_chk.sv ----
// Purpose: port-level checks for tmr16_ctrl
// Assumes: one clock, async active-low reset, full byte lanes on writes
// Notes:   control copies are taken at write acks, not from the design
`timescale 1ns/10ps
`include "tmr_defs.vh"
module tmr16_ctrl_chk (
    input wire        clock_in,
    input wire        reset_n_in,
    input wire [7:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0]  avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    input wire        cpu_wait_in,
    input wire        cpu_halt_in,
    input wire        cpu_irq_mask_in,
    input wire        timer_irq_out,
    input wire        wait_wake_out,
    input wire        compare_pin_one_out,
    input wire        compare_pin_one_sel_out,
    input wire        compare_pin_two_out,
    input wire        compare_pin_two_sel_out
);
    reg  [7:0] c1_r;
    reg  [7:0] c2_r;
    wire       ack = !avs_waitrequest_out;
    wire       wack = avs_write_in && ack && avs_byteenable_in[0];
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            c1_r <= 8'h00;
            c2_r <= 8'h00;
        end else begin
            if (wack && avs_address_in == `TMR_OFS_CTRL_ONE)
                c1_r <= avs_writedata_in[7:0];
            if (wack && avs_address_in == `TMR_OFS_CTRL_TWO)
                c2_r <= avs_writedata_in[7:0];
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    a_ack_next: assert property ((avs_read_in || avs_write_in) && !ack |=> ack)
        else $error("request not acked next cycle");
    a_ack_single: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ctrl_read: assert property (avs_read_in && ack && avs_address_in < 8'h08 |->
        avs_readdata_out == {24'h0, avs_address_in[2] ? c2_r : c1_r})
        else $error("control readback differs from last write");
    a_unmapped_zero: assert property (avs_read_in && ack && avs_address_in > 8'h1C |->
        avs_readdata_out == 32'h0) else $error("unmapped read not zero");
    a_mask_irq: assert property (cpu_irq_mask_in |=> !timer_irq_out)
        else $error("irq while masked");
    a_irq_quiet: assert property ((c1_r[7:5] == 3'h0) [*3] |-> !timer_irq_out)
        else $error("irq with all enables clear");
    a_wake_halt: assert property (cpu_halt_in || !cpu_wait_in |=> !wait_wake_out)
        else $error("wake outside wait or in halt");
    a_sel_route: assert property ($stable(c2_r) [*3] |->
        compare_pin_one_sel_out == c2_r[7] && compare_pin_two_sel_out == c2_r[6])
        else $error("pin select differs from enable bits");
    a_force_one: assert property (($stable({c1_r, c2_r}) && c1_r[3] && c2_r[7] &&
        c2_r[5:4] == 2'h0) [*3] |-> compare_pin_one_out == c1_r[0])
        else $error("forced pin one wrong");
    a_force_two: assert property (($stable({c1_r, c2_r}) && c1_r[4] && c2_r[6] &&
        c2_r[5:4] == 2'h0) [*3] |-> compare_pin_two_out == c1_r[2])
        else $error("forced pin two wrong");
endmodule

bind tmr16_ctrl tmr16_ctrl_chk chk (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .cpu_wait_in(cpu_wait_in),
    .cpu_halt_in(cpu_halt_in), .cpu_irq_mask_in(cpu_irq_mask_in),
    .timer_irq_out(timer_irq_out), .wait_wake_out(wait_wake_out),
    .compare_pin_one_out(compare_pin_one_out),
    .compare_pin_one_sel_out(compare_pin_one_sel_out),
    .compare_pin_two_out(compare_pin_two_out),
    .compare_pin_two_sel_out(compare_pin_two_sel_out));

// ---- tb/tmr16_ctrl_test.sv ----
// Purpose: self-checking bench for tmr16_ctrl
// Assumes: avalon ack after one cycle, 10 MHz clock
// Notes:   bus reads of the counter carry a tick or two of slack
`timescale 1ns/10ps
`include "tmr_defs.vh"
module tmr16_ctrl_test;
    reg         clock_in = 1'b0;
    reg         reset_n_in = 1'b0;
    reg  [7:0]  adr = 8'h00;
    reg         rd = 1'b0;
    reg         wr = 1'b0;
    reg  [31:0] wd = 32'h0;
    reg         cpu_wait = 1'b0;
    reg         cpu_halt = 1'b0;
    reg         mask = 1'b0;
    reg         cap = 1'b0;
    reg         ext = 1'b0;
    wire [31:0] rdata;
    wire        wreq, irq, wake, p1, p1s, p2, p2s;
    integer     failures = 0;
    integer     n_tests = 0;
    integer     i, k, r;
    reg  [31:0] q, c0, rnd;
    reg         pv;
    always #50 clock_in = ~clock_in;
    tmr16_ctrl dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .cpu_wait_in(cpu_wait), .cpu_halt_in(cpu_halt), .cpu_irq_mask_in(mask),
        .capture_pin_one_in(cap), .capture_pin_two_in(cap), .external_count_pin_in(ext),
        .timer_irq_out(irq), .wait_wake_out(wake), .compare_pin_one_out(p1),
        .compare_pin_one_sel_out(p1s), .compare_pin_two_out(p2),
        .compare_pin_two_sel_out(p2s));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function integer divof(input integer sel);
        divof = (sel == 0) ? 4 : (sel == 1) ? 2 : 8;
    endfunction
    task summarize;
        begin
            $display("failures=%0d n_tests=%0d", failures, n_tests);
            if (failures == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    task acc(input w, input [7:0] a, input [31:0] d);
        integer t;
        begin
            t = 0;
            @(posedge clock_in);
            adr <= a;
            wd <= d;
            rd <= !w;
            wr <= w;
            @(posedge clock_in);
            while (wreq !== 1'b0) begin
                t = t + 1;
                @(posedge clock_in);
            end
            check(t < 50, 1);
            q = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clock_in);
    endtask
    initial begin
        #(20000 * 100);
        failures = failures + 1;
        summarize;
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        rnd = 32'h0000FCAB;
        cyc(3);
        reset_n_in <= 1'b1;
        acc(0, `TMR_OFS_CTRL_ONE, 0);
        check(q, 0);
        acc(0, `TMR_OFS_CTRL_TWO, 0);
        check(q, 0);
        acc(1, 8'h20, 32'hFF);
        acc(0, 8'h20, 0);
        check(q, 0);
        for (i = 0; i < 6; i = i + 1) begin
            rnd = lfsr(rnd);
            acc(1, i[0] ? `TMR_OFS_CTRL_TWO : `TMR_OFS_CTRL_ONE, {24'h0, rnd[7:0]});
            acc(0, i[0] ? `TMR_OFS_CTRL_TWO : `TMR_OFS_CTRL_ONE, 0);
            check(q, {24'h0, rnd[7:0]});
        end
        acc(1, `TMR_OFS_CTRL_ONE, 0);
        // prescaler taps: count over a fixed span
        for (k = 0; k < 3; k = k + 1) begin
            acc(1, `TMR_OFS_CTRL_TWO, k << 2);
            acc(0, `TMR_OFS_COUNT, 0);
            c0 = q;
            cyc(64);
            acc(0, `TMR_OFS_COUNT, 0);
            r = (q[15:0] - c0[15:0]) * divof(k);
            check(r >= 56 && r <= 76, 1);
        end
        // external pin: six rises, five falls
        for (k = 0; k < 2; k = k + 1) begin
            acc(1, `TMR_OFS_CTRL_TWO, 8'h0C | k);
            acc(0, `TMR_OFS_COUNT, 0);
            c0 = q;
            for (i = 0; i < 6; i = i + 1) begin
                ext <= 1'b1;
                cyc(4);
                ext <= i == 5;
                cyc(4);
            end
            acc(0, `TMR_OFS_COUNT, 0);
            check(q[15:0] - c0[15:0], k ? 6 : 5);
            ext <= 1'b0;
            cyc(6);
        end
        // halt freezes; edge in halt only arms
        acc(1, `TMR_OFS_CTRL_TWO, 0);
        acc(1, `TMR_OFS_CTRL_ONE, 8'h02);
        acc(1, `TMR_OFS_STATUS, 32'h1F);
        cpu_halt <= 1'b1;
        cyc(2);
        acc(0, `TMR_OFS_COUNT, 0);
        c0 = q;
        cap <= 1'b1;
        cyc(40);
        acc(0, `TMR_OFS_COUNT, 0);
        check(q, c0);
        acc(0, `TMR_OFS_STATUS, 0);
        check(q[4], 0);
        cpu_halt <= 1'b0;
        cyc(6);
        acc(0, `TMR_OFS_STATUS, 0);
        check(q[4], 1);
        acc(0, `TMR_OFS_CAP_ONE, 0);
        check(q[15:0] - c0[15:0] <= 1, 1);
        // capture edges both ways, irq, mask, wake
        for (k = 0; k < 2; k = k + 1) begin
            acc(1, `TMR_OFS_CTRL_ONE, 8'h80 | (k << 1));
            acc(1, `TMR_OFS_CTRL_TWO, k << 1);
            cap <= k;
            cyc(6);
            acc(1, `TMR_OFS_STATUS, 32'h1F);
            cap <= !k;
            cyc(6);
            acc(0, `TMR_OFS_STATUS, 0);
            check({q[4], q[1]}, 0);
            cap <= k;
            cyc(6);
            acc(0, `TMR_OFS_STATUS, 0);
            check({q[4], q[1]}, 3);
            check(irq, 1);
        end
        mask <= 1'b1;
        cpu_wait <= 1'b1;
        cyc(3);
        check(irq, 0);
        check(wake, 1);
        cpu_halt <= 1'b1;
        cyc(3);
        check(wake, 0);
        cpu_halt <= 1'b0;
        cpu_wait <= 1'b0;
        mask <= 1'b0;
        // compare one match and overflow
        acc(1, `TMR_OFS_CTRL_ONE, 8'h61);
        acc(1, `TMR_OFS_CTRL_TWO, 8'h84);
        acc(1, `TMR_OFS_CMP_ONE, 32'h10);
        acc(1, `TMR_OFS_COUNT, 0);
        acc(1, `TMR_OFS_STATUS, 32'h1F);
        r = 0;
        while (p1 !== 1'b1 && r < 300) begin
            r = r + 1;
            @(posedge clock_in);
        end
        check(p1, 1);
        cyc(2);
        check(irq, 1);
        acc(0, `TMR_OFS_STATUS, 0);
        check(q[4:0], 5'h0C);
        acc(1, `TMR_OFS_CTRL_ONE, 8'h21);
        cyc(2);
        check(irq, 1);
        acc(1, `TMR_OFS_STATUS, 32'h04);
        cyc(2);
        check(irq, 0);
        // forced levels on both pins
        acc(1, `TMR_OFS_CTRL_TWO, 8'hC0);
        for (k = 0; k < 4; k = k + 1) begin
            acc(1, `TMR_OFS_CTRL_ONE, k[1] ? (8'h10 | (k[0] << 2)) : (8'h08 | k[0]));
            cyc(3);
            check(k[1] ? p2 : p1, k[0]);
        end
        // pwm with single pulse also set: pwm alone runs
        acc(1, `TMR_OFS_CMP_ONE, 32'h08);
        acc(1, `TMR_OFS_CMP_TWO, 32'h20);
        acc(1, `TMR_OFS_CTRL_ONE, 8'h84);
        acc(1, `TMR_OFS_CTRL_TWO, 8'hB4);
        acc(1, `TMR_OFS_COUNT, 0);
        acc(1, `TMR_OFS_STATUS, 32'h1F);
        r = 0;
        for (i = 0; i < 400; i = i + 1) begin
            pv = p1;
            @(posedge clock_in);
            r = r + (p1 === 1'b1 && pv === 1'b0);
        end
        check(r >= 4 && r <= 6, 1);
        acc(0, `TMR_OFS_STATUS, 0);
        check({q[4:3], q[0]}, 3'h4);
        // single pulse: rising edge on capture one starts it
        acc(1, `TMR_OFS_CTRL_TWO, 8'hA4);
        acc(1, `TMR_OFS_CTRL_ONE, 8'h06);
        cap <= 1'b0;
        cyc(6);
        acc(1, `TMR_OFS_STATUS, 32'h1F);
        cap <= 1'b1;
        cyc(6);
        check(p1, 1);
        acc(0, `TMR_OFS_CAP_ONE, 0);
        check(q, 32'hFFFD);
        acc(0, `TMR_OFS_STATUS, 0);
        check(q[4], 1);
        cyc(40);
        check(p1, 0);
        summarize;
    end
endmodule
